// [pwp_pkg.sv]
package pwp_pkg;

	localparam int          NPAIR          = 3;
	localparam int          IDX_W          = 14;

	localparam logic [13:0] IDX_CTRL_LOW   = 14'h0040;
	localparam logic [13:0] IDX_CTRL_HIGH  = 14'h0041;
	localparam logic [13:0] IDX_INV_HIGH   = 14'h0050;
	localparam logic [13:0] IDX_DT_LOW     = 14'h0058;
	localparam logic [13:0] IDX_DT_HIGH    = 14'h0059;
	localparam logic [13:0] IDX_MAP1_LOW   = 14'h005c;
	localparam logic [13:0] IDX_MAP1_HIGH  = 14'h005d;
	localparam logic [13:0] IDX_MAP2_LOW   = 14'h005e;
	localparam logic [13:0] IDX_CFG_LOW    = 14'h1820;
	localparam logic [13:0] IDX_CFG_HIGH   = 14'h1821;

	localparam int          CFGL_WP_BIT    = 0;
	localparam int          CFGL_PAIR_LSB  = 1;
	localparam int          CFGL_BOT_LSB   = 4;
	localparam int          CTH_EXT_BIT    = 0;
	localparam int          CTL_SWAP_LSB   = 0;
	localparam int          CTL_LOAD_LSB   = 4;

	localparam logic [7:0]  MASK_FULL      = 8'hff;
	localparam logic [7:0]  MASK_NONE      = 8'h00;
	localparam logic [7:0]  MASK_CFG_LOW   = 8'h7f;
	localparam logic [7:0]  MASK_CFG_HIGH  = 8'h77;
	localparam logic [7:0]  MASK_DT_HIGH   = 8'h0f;
	localparam logic [7:0]  MASK_CTL_LOW   = 8'h37;
	localparam logic [7:0]  MASK_CTH       = 8'h01;

	localparam logic [7:0]  RST_MAP        = 8'hff;
	localparam logic [7:0]  RST_DT_LOW     = 8'hff;
	localparam logic [3:0]  RST_DT_HIGH    = 4'hf;
	localparam logic [7:0]  RST_BYTE       = 8'h00;

	typedef enum logic [3:0] {
		SEL_NONE,
		SEL_CTRL_LOW,
		SEL_CTRL_HIGH,
		SEL_INV_HIGH,
		SEL_DT_LOW,
		SEL_DT_HIGH,
		SEL_MAP1_LOW,
		SEL_MAP1_HIGH,
		SEL_MAP2_LOW,
		SEL_CFG_LOW,
		SEL_CFG_HIGH
	} pwp_sel_t;

	typedef struct packed {
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
		logic [7:0]  inv_high;
		logic [7:0]  map1_low;
		logic [7:0]  map1_high;
		logic [7:0]  map2_low;
		logic [7:0]  dt_low;
		logic [3:0]  dt_high;
		logic [7:0]  cfg_low;
		logic [7:0]  cfg_high;
		logic        ext_access;
		logic [7:0]  ctl_low;
		logic [5:0]  chan_cmpl;
		logic [2:0]  dt_en;
	} pwp_state_t;

	localparam pwp_state_t STATE_RST = '{
		pready:     1'b0,
		pslverr:    1'b0,
		prdata:     32'h0000_0000,
		inv_high:   RST_BYTE,
		map1_low:   RST_MAP,
		map1_high:  RST_MAP,
		map2_low:   RST_MAP,
		dt_low:     RST_DT_LOW,
		dt_high:    RST_DT_HIGH,
		cfg_low:    RST_BYTE,
		cfg_high:   RST_BYTE,
		ext_access: 1'b0,
		ctl_low:    RST_BYTE,
		chan_cmpl:  6'h3f,
		dt_en:      3'h7
	};

	function automatic pwp_sel_t pwp_decode(input logic [13:0] idx);
		case (idx)
			IDX_CTRL_LOW:  return SEL_CTRL_LOW;
			IDX_CTRL_HIGH: return SEL_CTRL_HIGH;
			IDX_INV_HIGH:  return SEL_INV_HIGH;
			IDX_DT_LOW:    return SEL_DT_LOW;
			IDX_DT_HIGH:   return SEL_DT_HIGH;
			IDX_MAP1_LOW:  return SEL_MAP1_LOW;
			IDX_MAP1_HIGH: return SEL_MAP1_HIGH;
			IDX_MAP2_LOW:  return SEL_MAP2_LOW;
			IDX_CFG_LOW:   return SEL_CFG_LOW;
			IDX_CFG_HIGH:  return SEL_CFG_HIGH;
			default:       return SEL_NONE;
		endcase
	endfunction : pwp_decode

	function automatic logic [7:0] pwp_merge(input logic [7:0] old_v, input logic [7:0] new_v,
		input logic [7:0] mask);
		return (old_v & ~mask) | (new_v & mask);
	endfunction : pwp_merge

endpackage : pwp_pkg

// [pwp_wr_if.sv]
`timescale 1ns/1ps
interface pwp_wr_if;
	import pwp_pkg::*;
	pwp_sel_t   sel;
	logic       wp;
	logic       ext_access;
	logic [7:0] mask;

	modport src  (output sel, output wp, output ext_access, input mask);
	modport gate (input sel, input wp, input ext_access, output mask);
endinterface : pwp_wr_if

// [pwp_wr_gate.sv]
`timescale 1ns/1ps
module pwp_wr_gate (
	pwp_wr_if.gate wif
);
	import pwp_pkg::*;

	// Per-bit write permission for the selected register
	always_comb begin
		wif.mask = MASK_NONE;
		case (wif.sel)
			SEL_INV_HIGH,
			SEL_DT_LOW,
			SEL_MAP1_LOW,
			SEL_MAP1_HIGH,
			SEL_MAP2_LOW: begin
				wif.mask = wif.wp ? MASK_NONE : MASK_FULL;
			end
			SEL_DT_HIGH: begin
				wif.mask = wif.wp ? MASK_NONE : MASK_DT_HIGH;
			end
			SEL_CFG_LOW: begin
				// Mask comes from the old lock, so the locking write lands whole
				wif.mask = wif.wp ? MASK_NONE : MASK_CFG_LOW;
			end
			SEL_CFG_HIGH: begin
				wif.mask = wif.wp ? MASK_NONE : MASK_CFG_HIGH;
			end
			SEL_CTRL_HIGH: begin
				wif.mask = wif.wp ? MASK_NONE : MASK_CTH;
			end
			SEL_CTRL_LOW: begin
				wif.mask = wif.ext_access ? MASK_CTL_LOW : MASK_NONE;
			end
			default: begin
				wif.mask = MASK_NONE;
			end
		endcase
	end

endmodule : pwp_wr_gate

// [pwp_config_protect.sv]
// Implementation choice: the APB register port.
`timescale 1ns/1ps
module pwp_config_protect #(
	parameter int ADDR_W = 16
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	input  wire logic [3:0]        pstrb,
	output wire logic [31:0]       prdata,
	output wire logic              pready,
	output wire logic              pslverr,
	output wire logic [2:0]        bottom_polarity,
	output wire logic [2:0]        pair_mode_select,
	output wire logic [5:0]        chan_complementary,
	output wire logic [2:0]        deadtime_pair_en,
	output wire logic [11:0]       deadtime_value,
	output wire logic              write_protect,
	output wire logic              enhanced_access_enable,
	output wire logic [1:0]        value_load_mode,
	output wire logic [2:0]        swap_pairs,
	output wire logic [7:0]        channel_inversion_high,
	output wire logic [23:0]       disable_map,
	output wire logic [7:0]        config_high
);
	import pwp_pkg::*;

	if (ADDR_W < 16 || ADDR_W > 32) begin : g_bad_addr_w
		$error("ADDR_W must be 16 to 32");
	end

	pwp_state_t        s_r;
	pwp_state_t        s_nxt;
	logic [ADDR_W-1:0] word_idx;
	logic              aligned;
	pwp_sel_t          sel;
	logic              access;
	logic              commit;
	logic              wr;
	logic [7:0]        rd_byte;
	logic [7:0]        wd;
	logic [7:0]        wm;
	logic [7:0]        dt_high_m;

	pwp_wr_if wif ();

	pwp_wr_gate u_gate (
		.wif (wif)
	);

	// Decode; misaligned or out-of-range addresses hit nothing
	assign word_idx = paddr >> 2;
	assign aligned  = (paddr[1:0] == 2'b00) && (word_idx[ADDR_W-1:IDX_W] == '0);
	assign sel      = aligned ? pwp_decode(word_idx[IDX_W-1:0]) : SEL_NONE;
	assign access   = psel && penable;
	assign commit   = access && s_r.pready;
	assign wr       = commit && pwrite && pstrb[0];
	assign wd       = pwdata[7:0];
	assign wm       = wif.mask;
	assign dt_high_m = pwp_merge({4'h0, s_r.dt_high}, wd, wm);

	assign wif.sel        = sel;
	assign wif.wp         = s_r.cfg_low[CFGL_WP_BIT];
	assign wif.ext_access = s_r.ext_access;

	// Read view; reserved bits are never stored, so they read zero
	always_comb begin
		rd_byte = 8'h00;
		case (sel)
			SEL_CTRL_LOW:  rd_byte = s_r.ctl_low;
			SEL_CTRL_HIGH: rd_byte = {7'h00, s_r.ext_access};
			SEL_INV_HIGH:  rd_byte = s_r.inv_high;
			SEL_DT_LOW:    rd_byte = s_r.dt_low;
			SEL_DT_HIGH:   rd_byte = {4'h0, s_r.dt_high};
			SEL_MAP1_LOW:  rd_byte = s_r.map1_low;
			SEL_MAP1_HIGH: rd_byte = s_r.map1_high;
			SEL_MAP2_LOW:  rd_byte = s_r.map2_low;
			SEL_CFG_LOW:   rd_byte = s_r.cfg_low;
			SEL_CFG_HIGH:  rd_byte = s_r.cfg_high & MASK_CFG_HIGH;
			default:       rd_byte = 8'h00;
		endcase
	end

	always_comb begin
		s_nxt = s_r;
		// One wait state keeps every bus output on a flip-flop
		s_nxt.pready  = access && !s_r.pready;
		s_nxt.pslverr = 1'b0;
		if (access && !s_r.pready && !pwrite) begin
			s_nxt.prdata = {24'h00_0000, rd_byte};
		end
		if (wr) begin
			case (sel)
				SEL_INV_HIGH: begin
					s_nxt.inv_high = pwp_merge(s_r.inv_high, wd, wm);
				end
				SEL_DT_LOW: begin
					s_nxt.dt_low = pwp_merge(s_r.dt_low, wd, wm);
				end
				SEL_DT_HIGH: begin
					s_nxt.dt_high = dt_high_m[3:0];
				end
				SEL_MAP1_LOW: begin
					s_nxt.map1_low = pwp_merge(s_r.map1_low, wd, wm);
				end
				SEL_MAP1_HIGH: begin
					s_nxt.map1_high = pwp_merge(s_r.map1_high, wd, wm);
				end
				SEL_MAP2_LOW: begin
					s_nxt.map2_low = pwp_merge(s_r.map2_low, wd, wm);
				end
				SEL_CFG_LOW: begin
					s_nxt.cfg_low = pwp_merge(s_r.cfg_low, wd, wm);
				end
				SEL_CFG_HIGH: begin
					s_nxt.cfg_high = pwp_merge(s_r.cfg_high, wd, wm);
				end
				SEL_CTRL_HIGH: begin
					if (wm[CTH_EXT_BIT]) begin
						s_nxt.ext_access = wd[CTH_EXT_BIT];
					end
				end
				SEL_CTRL_LOW: begin
					s_nxt.ctl_low = pwp_merge(s_r.ctl_low, wd, wm);
				end
				default: begin
					// Unmapped writes are simply dropped
					s_nxt.ctl_low = s_r.ctl_low;
				end
			endcase
		end
		// Lock only ever sets; no write can bring it back
		s_nxt.cfg_low[CFGL_WP_BIT] = s_r.cfg_low[CFGL_WP_BIT] | s_nxt.cfg_low[CFGL_WP_BIT];
		for (int k = 0; k < NPAIR; k++) begin
			s_nxt.chan_cmpl[2*k +: 2] = {2{~s_nxt.cfg_low[CFGL_PAIR_LSB+k]}};
		end
		// Independent channels get no deadtime
		s_nxt.dt_en = ~s_nxt.cfg_low[CFGL_PAIR_LSB +: NPAIR];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r <= STATE_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign prdata                 = s_r.prdata;
	assign pready                 = s_r.pready;
	assign pslverr                = s_r.pslverr;
	assign bottom_polarity        = s_r.cfg_low[CFGL_BOT_LSB +: NPAIR];
	assign pair_mode_select       = s_r.cfg_low[CFGL_PAIR_LSB +: NPAIR];
	assign chan_complementary     = s_r.chan_cmpl;
	assign deadtime_pair_en       = s_r.dt_en;
	assign deadtime_value         = {s_r.dt_high, s_r.dt_low};
	assign write_protect          = s_r.cfg_low[CFGL_WP_BIT];
	assign enhanced_access_enable = s_r.ext_access;
	assign value_load_mode        = s_r.ctl_low[CTL_LOAD_LSB +: 2];
	assign swap_pairs             = s_r.ctl_low[CTL_SWAP_LSB +: NPAIR];
	assign channel_inversion_high = s_r.inv_high;
	assign disable_map            = {s_r.map2_low, s_r.map1_high, s_r.map1_low};
	assign config_high            = s_r.cfg_high;

	bot_pol_map_a : assert property (
		@(posedge pclk) disable iff (!presetn)
		(wr && sel == SEL_CFG_LOW && !write_protect)
		|=> bottom_polarity == $past(pwdata[6:4]))
		else $error("bottom polarity not taken from config write");

	pair_mode_a : assert property (
		@(posedge pclk) disable iff (!presetn)
		(wr && sel == SEL_CFG_LOW && !write_protect)
		|=> pair_mode_select == $past(pwdata[3:1]))
		else $error("pair mode not taken from config write");

	pair_fixed_a : assert property (
		@(posedge pclk) disable iff (!presetn)
		chan_complementary == {{2{~pair_mode_select[2]}}, {2{~pair_mode_select[1]}},
			{2{~pair_mode_select[0]}}})
		else $error("channel pairing wrong");

	open_write_a : assert property (
		@(posedge pclk) disable iff (!presetn)
		(wr && sel == SEL_MAP1_LOW && !write_protect)
		|=> disable_map[7:0] == $past(pwdata[7:0]))
		else $error("open write not accepted");

	locked_hold_a : assert property (
		@(posedge pclk) disable iff (!presetn)
		(write_protect && wr && (sel == SEL_DT_LOW || sel == SEL_DT_HIGH))
		|=> $stable(deadtime_value))
		else $error("locked deadtime changed");

	wp_sticky_a : assert property (
		@(posedge pclk) disable iff (!presetn)
		write_protect |=> write_protect [*3])
		else $error("write protect cleared");

	prot_set_a : assert property (
		@(posedge pclk) disable iff (!presetn)
		write_protect |=> $stable({channel_inversion_high, disable_map, deadtime_value,
			config_high, bottom_polarity, pair_mode_select, enhanced_access_enable}))
		else $error("protected register changed while locked");

	ext_lock_a : assert property (
		@(posedge pclk) disable iff (!presetn)
		!enhanced_access_enable |=> $stable({value_load_mode, swap_pairs}))
		else $error("control low changed without extended access");

	ext_chain_a : assert property (
		@(posedge pclk) disable iff (!presetn)
		(write_protect && wr && sel == SEL_CTRL_HIGH)
		|=> enhanced_access_enable == $past(enhanced_access_enable))
		else $error("extended access bit changed while locked");

	wp_full_write_a : assert property (
		@(posedge pclk) disable iff (!presetn)
		(wr && sel == SEL_CFG_LOW && !write_protect && pwdata[0])
		|=> write_protect && pair_mode_select == $past(pwdata[3:1])
			&& bottom_polarity == $past(pwdata[6:4]))
		else $error("locking write not applied in full");

	cfgh_bit7_a : assert property (
		@(posedge pclk) disable iff (!presetn)
		(access && !pready && !pwrite && sel == SEL_CFG_HIGH)
		|=> pready && prdata[7] == 1'b0)
		else $error("config high bit 7 read nonzero");

	dt_comp_only_a : assert property (
		@(posedge pclk) disable iff (!presetn)
		deadtime_pair_en == ~pair_mode_select)
		else $error("deadtime enabled on independent pair");

	no_error_a : assert property (
		@(posedge pclk) disable iff (!presetn)
		(access && !pready) |=> pready && !pslverr ##1 !pready)
		else $error("bus answer late or flagged an error");

	bot_pol_hold_a : assert property (
		@(posedge pclk) disable iff (!presetn)
		!(wr && sel == SEL_CFG_LOW) |=> $stable(bottom_polarity))
		else $error("bottom polarity changed without config write");

	pair_mode_hold_a : assert property (
		@(posedge pclk) disable iff (!presetn)
		!(wr && sel == SEL_CFG_LOW) |=> $stable(pair_mode_select))
		else $error("pair mode changed without config write");

	pair_dt_match_a : assert property (
		@(posedge pclk) disable iff (!presetn)
		chan_complementary == {{2{deadtime_pair_en[2]}}, {2{deadtime_pair_en[1]}},
			{2{deadtime_pair_en[0]}}})
		else $error("pair grouping differs from deadtime grouping");

	open_inv_a : assert property (
		@(posedge pclk) disable iff (!presetn)
		(wr && sel == SEL_INV_HIGH && !write_protect)
		|=> channel_inversion_high == $past(pwdata[7:0]))
		else $error("open inversion write not accepted");

	open_dt_a : assert property (
		@(posedge pclk) disable iff (!presetn)
		(wr && sel == SEL_DT_LOW && !write_protect)
		|=> deadtime_value[7:0] == $past(pwdata[7:0]))
		else $error("open deadtime write not accepted");

	open_map2_a : assert property (
		@(posedge pclk) disable iff (!presetn)
		(wr && sel == SEL_MAP2_LOW && !write_protect)
		|=> disable_map[23:16] == $past(pwdata[7:0]))
		else $error("open map write not accepted");

	locked_map_a : assert property (
		@(posedge pclk) disable iff (!presetn)
		(write_protect && wr && sel == SEL_MAP2_LOW)
		|=> $stable(disable_map))
		else $error("locked map changed");

	lock_mask_a : assert property (
		@(posedge pclk) disable iff (!presetn)
		(write_protect && sel != SEL_CTRL_LOW) |-> wm == MASK_NONE)
		else $error("write permitted while locked");

	wp_no_clear_a : assert property (
		@(posedge pclk) disable iff (!presetn)
		(write_protect && wr && sel == SEL_CFG_LOW)
		|=> write_protect && $stable(pair_mode_select))
		else $error("config write accepted while locked");

	cfg_low_frozen_a : assert property (
		@(posedge pclk) disable iff (!presetn)
		write_protect |=> $stable(s_r.cfg_low))
		else $error("config low changed while locked");

	ctl_open_a : assert property (
		@(posedge pclk) disable iff (!presetn)
		(wr && sel == SEL_CTRL_LOW && enhanced_access_enable)
		|=> swap_pairs == $past(pwdata[2:0])
			&& value_load_mode == $past(pwdata[5:4]))
		else $error("control low write not accepted with extended access");

	ext_open_a : assert property (
		@(posedge pclk) disable iff (!presetn)
		(wr && sel == SEL_CTRL_HIGH && !write_protect)
		|=> enhanced_access_enable == $past(pwdata[0]))
		else $error("extended access write not accepted while open");

	wp_set_once_a : assert property (
		@(posedge pclk) disable iff (!presetn)
		(wr && sel == SEL_CFG_LOW && !write_protect && pwdata[0])
		|=> s_r.cfg_low == $past({1'b0, pwdata[6:0]}))
		else $error("locking write not stored whole");

	cfgh_rsvd_a : assert property (
		@(posedge pclk) disable iff (!presetn)
		!config_high[7] && !config_high[3])
		else $error("config high reserved bit set");

	dt_en_hold_a : assert property (
		@(posedge pclk) disable iff (!presetn)
		!(wr && sel == SEL_CFG_LOW) |=> $stable(deadtime_pair_en))
		else $error("deadtime enables changed without config write");

	unmapped_rd_a : assert property (
		@(posedge pclk) disable iff (!presetn)
		(access && !pready && !pwrite && sel == SEL_NONE)
		|=> prdata == 32'h0000_0000)
		else $error("unmapped read returned data");

	no_slverr_a : assert property (
		@(posedge pclk) disable iff (!presetn)
		!pslverr)
		else $error("bus error flagged");

	strobe_drop_a : assert property (
		@(posedge pclk) disable iff (!presetn)
		(commit && pwrite && !pstrb[0])
		|=> $stable({channel_inversion_high, disable_map, deadtime_value, config_high,
			write_protect}))
		else $error("write without byte strobe changed a register");

endmodule : pwp_config_protect

// [pwp_config_protect_tb.sv]
`timescale 1ns/1ps
module pwp_config_protect_tb;
	import pwp_pkg::*;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [15:0] paddr;
	logic [31:0] pwdata;
	logic [3:0]  pstrb;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [2:0]  bottom_polarity;
	logic [2:0]  pair_mode_select;
	logic [5:0]  chan_complementary;
	logic [2:0]  deadtime_pair_en;
	logic [11:0] deadtime_value;
	logic        write_protect;
	logic        enhanced_access_enable;
	logic [1:0]  value_load_mode;
	logic [2:0]  swap_pairs;
	logic [7:0]  channel_inversion_high;
	logic [23:0] disable_map;
	logic [7:0]  config_high;
	logic [31:0] rd;
	int          err_count;
	int          checked;

	// Every protected register but config low, its reset value, a test value and what reads back
	localparam logic [13:0] RIDX [8] = '{IDX_INV_HIGH, IDX_MAP1_LOW, IDX_MAP1_HIGH,
		IDX_MAP2_LOW, IDX_DT_LOW, IDX_DT_HIGH, IDX_CFG_HIGH, IDX_CTRL_HIGH};
	localparam logic [7:0]  RVAL [8] = '{8'h00, 8'hff, 8'hff, 8'hff, 8'hff, 8'h0f, 8'h00, 8'h00};
	localparam logic [7:0]  WVAL [8] = '{8'ha5, 8'h12, 8'h34, 8'h56, 8'h9c, 8'hfa, 8'hff, 8'hff};
	localparam logic [7:0]  WEXP [8] = '{8'ha5, 8'h12, 8'h34, 8'h56, 8'h9c, 8'h0a, 8'h77, 8'h01};

	pwp_config_protect #(
		.ADDR_W(16)
	) u_pwp_config_protect (
		.pclk                   (pclk),
		.presetn                (presetn),
		.psel                   (psel),
		.penable                (penable),
		.pwrite                 (pwrite),
		.paddr                  (paddr),
		.pwdata                 (pwdata),
		.pstrb                  (pstrb),
		.prdata                 (prdata),
		.pready                 (pready),
		.pslverr                (pslverr),
		.bottom_polarity        (bottom_polarity),
		.pair_mode_select       (pair_mode_select),
		.chan_complementary     (chan_complementary),
		.deadtime_pair_en       (deadtime_pair_en),
		.deadtime_value         (deadtime_value),
		.write_protect          (write_protect),
		.enhanced_access_enable (enhanced_access_enable),
		.value_load_mode        (value_load_mode),
		.swap_pairs             (swap_pairs),
		.channel_inversion_high (channel_inversion_high),
		.disable_map            (disable_map),
		.config_high            (config_high)
	);

	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
			err_count++;
		end
	endtask : chk

	task automatic results;
		$display("Mismatches %0d, comparisons %0d", err_count, checked);
		if (err_count == 0 && checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : results

	// Idle cycle after each transfer, so no signal is driven twice in one step
	task automatic apb(input logic w, input logic [13:0] idx, input logic [7:0] wd,
		input logic [3:0] st);
		int n;
		n = 0;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= {idx, 2'b00};
		pwdata  <= {24'h0, wd};
		pstrb   <= st;
		@(posedge pclk);
		penable <= 1'b1;
		// Read right after the edge, before its updates land: the value that stood
		@(posedge pclk);
		while (pready !== 1'b1) begin
			n++;
			if (n > 16) begin
				err_count++;
				results();
			end
			@(posedge pclk);
		end
		rd = prdata;
		chk(pslverr, 1'b0);
		psel    <= 1'b0;
		penable <= 1'b0;
		@(negedge pclk);
	endtask : apb

	task automatic wr(input logic [13:0] idx, input logic [7:0] d);
		apb(1'b1, idx, d, 4'h1);
	endtask : wr

	task automatic rc(input logic [13:0] idx, input logic [7:0] e);
		apb(1'b0, idx, 8'h00, 4'h1);
		chk(rd, {24'h0, e});
	endtask : rc

	task automatic do_reset;
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(negedge pclk);
	endtask : do_reset

	initial begin
		presetn   = 1'b0;
		psel      = 1'b0;
		penable   = 1'b0;
		pwrite    = 1'b0;
		paddr     = 16'h0000;
		pwdata    = 32'h0000_0000;
		pstrb     = 4'h0;
		err_count = 0;
		checked   = 0;
		do_reset();
		chk(disable_map, 24'hffffff);
		chk(deadtime_value, 12'hfff);
		chk(chan_complementary, 6'h3f);
		chk(deadtime_pair_en, 3'h7);
		chk(write_protect, 1'b0);
		for (int i = 0; i < 8; i++) begin
			rc(RIDX[i], RVAL[i]);
		end
		rc(14'h0100, 8'h00);
		// Swap and load fields stay frozen until extended access is granted
		wr(IDX_CTRL_LOW, 8'h33);
		rc(IDX_CTRL_LOW, 8'h00);
		for (int i = 0; i < 8; i++) begin
			wr(RIDX[i], WVAL[i]);
			rc(RIDX[i], WEXP[i]);
		end
		chk(config_high, 8'h77);
		chk(deadtime_value, 12'ha9c);
		chk(disable_map, 24'h563412);
		chk(channel_inversion_high, 8'ha5);
		chk(enhanced_access_enable, 1'b1);
		wr(IDX_CTRL_LOW, 8'h31);
		chk({value_load_mode, swap_pairs}, 5'h19);
		wr(IDX_CFG_LOW, 8'hd4);
		rc(IDX_CFG_LOW, 8'h54);
		chk({bottom_polarity, pair_mode_select}, 6'h2a);
		chk(chan_complementary, 6'h33);
		chk(deadtime_pair_en, 3'h5);
		// Locking write also changes every other field of the register
		wr(IDX_CFG_LOW, 8'h2b);
		rc(IDX_CFG_LOW, 8'h2b);
		chk({bottom_polarity, pair_mode_select}, 6'h15);
		chk(chan_complementary, 6'h0c);
		chk(deadtime_pair_en, 3'h2);
		chk(write_protect, 1'b1);
		for (int i = 0; i < 8; i++) begin
			wr(RIDX[i], ~WVAL[i]);
			rc(RIDX[i], WEXP[i]);
		end
		chk(enhanced_access_enable, 1'b1);
		wr(IDX_CFG_LOW, 8'h00);
		rc(IDX_CFG_LOW, 8'h2b);
		wr(IDX_CTRL_LOW, 8'h12);
		rc(IDX_CTRL_LOW, 8'h12);
		do_reset();
		chk(write_protect, 1'b0);
		wr(IDX_INV_HIGH, 8'h3c);
		rc(IDX_INV_HIGH, 8'h3c);
		apb(1'b1, IDX_INV_HIGH, 8'hff, 4'h0);
		rc(IDX_INV_HIGH, 8'h3c);
		results();
	end
endmodule : pwp_config_protect_tb
